//--- pkg/anbp_pkg.sv
// Shared constants, types and register map of the NAND-style bus host port
package anbp_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_STAGES   = 3;

  // Pin phase times, least times rounded up to whole cycles
  localparam int SETUP_NS      = 20;
  localparam int STROBE_NS     = 30;
  localparam int HOLD_NS       = 10;
  localparam int SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC      = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Read strobe stays low long enough for returned data to clear the synchroniser
  localparam int RD_STROBE_CYC = STROBE_CYC + SYNC_STAGES + 1;

  localparam logic [2:0] ADDR_BYTES = 3'h5;
  localparam logic [2:0] ADDR_USED  = 3'h3;
  localparam int         A20_BIT    = 20;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_OP     = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;

  // Field positions
  localparam int CTRL_WPN_BIT   = 0;
  localparam int CTRL_WIDE_BIT  = 1;
  localparam int CTRL_HSR_BIT   = 2;
  localparam int OP_KIND_LSB    = 16;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_RDY_BIT     = 1;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_POWERED_BIT = 3;

  localparam logic [2:0]  CTRL_RESET   = 3'h1;
  localparam logic [7:0]  CMD_STATUS   = 8'h70;
  localparam logic [7:0]  CMD_RESET    = 8'hFF;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    OP_CMD,
    OP_ADDR,
    OP_WR,
    OP_RD
  } anbp_op_type;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
    logic hw_store_request_n;
  } anbp_pins_type;

  localparam anbp_pins_type PINS_IDLE = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage

//--- rtl/anbp_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module anbp_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Change counts only once the last two stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST_VAL;
    end else if (s2_r == s3_r) begin
      q <= s3_r;
    end
  end
endmodule
`default_nettype wire

//--- rtl/anbp_host.sv
// Host controller for the NAND-style nonvolatile SRAM bus, AXI4-Lite programmed
// What this block does
// - Word mode: commands, addresses on low byte
// - Host issues nothing until ready/busy first goes high, then only status and reset commands while it is low
// - Command, address and data cycles, sent in whatever order software writes the operations
// - Five address bytes, least significant first
// - Host drives the fourth and fifth address bytes zero, and A20 in word mode
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module anbp_host
  import anbp_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output anbp_pkg::anbp_pins_type      pins,
  output logic [15:0]                  dq_o,
  output logic [1:0]                   dq_oe,
  input  wire logic [15:0]             dq_i,
  input  wire logic                    ready_busy_i
);
  import anbp_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_END} anbp_state_type;

  anbp_state_type state_r;
  anbp_op_type    kind_r;
  logic [2:0]     ctrl_r;
  logic [23:0]    addr_r;
  logic [15:0]    wdata_r;
  logic [15:0]    rdata_r;
  logic [7:0]     cnt_r;
  logic [2:0]     byte_idx_r;
  logic           refused_r;
  logic           powered_r;
  logic           aw_full_r;
  logic           w_full_r;
  logic [7:0]     awaddr_q_r;
  logic [31:0]    wdata_q_r;
  logic           rb_sync;
  logic [15:0]    dq_sync;
  logic [2:0]     addr_edges_r;

  anbp_sync #(.W(1), .RST_VAL(1'b0)) u_rb_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (ready_busy_i),
    .q     (rb_sync)
  );

  anbp_sync #(.W(16), .RST_VAL(16'h0000)) u_dq_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (dq_i),
    .q     (dq_sync)
  );

  // AXI write path
  logic        do_write;
  logic        op_hit;
  logic        op_allowed;
  anbp_op_type op_kind;
  logic [7:0]  op_byte;
  assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;
  assign op_hit   = do_write && (awaddr_q_r == REG_OP);
  assign op_kind  = anbp_op_type'(wdata_q_r[OP_KIND_LSB +: 2]);
  assign op_byte  = wdata_q_r[7:0];
  // While busy only status read and reset commands are worth sending
  assign op_allowed = (state_r == S_IDLE) && powered_r &&
                      (rb_sync || (op_kind == OP_CMD &&
                       (op_byte == CMD_STATUS || op_byte == CMD_RESET)));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_r     <= 1'b0;
      awaddr_q_r    <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r  <= 1'b1;
        awaddr_q_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full_r <= 1'b0;
      end
      s_axi_awready <= !(aw_full_r || (s_axi_awvalid && s_axi_awready)) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_full_r     <= 1'b0;
      wdata_q_r    <= 32'h0000_0000;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r  <= 1'b1;
        wdata_q_r <= s_axi_wdata;
      end else if (do_write) begin
        w_full_r <= 1'b0;
      end
      s_axi_wready <= !(w_full_r || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;
    end
  end

  // Byte strobes ignored: every register is written whole
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      ctrl_r       <= CTRL_RESET;
      addr_r       <= 24'h00_0000;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end else if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OKAY;
        case (awaddr_q_r)
          REG_CTRL:   ctrl_r <= wdata_q_r[2:0];
          REG_ADDR:   addr_r <= wdata_q_r[23:0];
          REG_OP:     s_axi_bresp <= RESP_OKAY;
          REG_STATUS: s_axi_bresp <= RESP_OKAY;
          REG_RDATA:  s_axi_bresp <= RESP_OKAY;
          default:    s_axi_bresp <= RESP_SLVERR;
        endcase
      end
    end
  end

  // Refused flag: a new refusal wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refused_r <= 1'b0;
    end else if (op_hit && !op_allowed) begin
      refused_r <= 1'b1;
    end else if (do_write && awaddr_q_r == REG_STATUS && wdata_q_r[ST_REFUSED_BIT]) begin
      refused_r <= 1'b0;
    end
  end

  // Power-up recall: wait until the device first releases ready/busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      powered_r <= 1'b0;
    end else if (rb_sync) begin
      powered_r <= 1'b1;
    end
  end

  // AXI read path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OKAY;
        s_axi_rdata   <= 32'h0000_0000;
        case (s_axi_araddr)
          REG_CTRL:   s_axi_rdata[2:0] <= ctrl_r;
          REG_ADDR:   s_axi_rdata[23:0] <= addr_r;
          REG_OP:     s_axi_rdata[OP_KIND_LSB +: 2] <= kind_r;
          REG_STATUS: s_axi_rdata[3:0] <= {powered_r, refused_r, rb_sync,
                                           state_r != S_IDLE};
          REG_RDATA:  s_axi_rdata[15:0] <= rdata_r;
          default:    s_axi_rresp <= RESP_SLVERR;
        endcase
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Pin sequencer: setup, strobe, hold per bus cycle
  logic [7:0] strobe_len;
  assign strobe_len = (kind_r == OP_RD) ? 8'(RD_STROBE_CYC) : 8'(STROBE_CYC);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= S_IDLE;
      kind_r     <= OP_CMD;
      cnt_r      <= 8'h00;
      byte_idx_r <= 3'h0;
      wdata_r    <= 16'h0000;
      rdata_r    <= 16'h0000;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (op_hit && op_allowed) begin
            kind_r     <= op_kind;
            wdata_r    <= wdata_q_r[15:0];
            byte_idx_r <= 3'h0;
            cnt_r      <= 8'h00;
            state_r    <= S_SETUP;
          end
        end
        S_SETUP: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(SETUP_CYC - 1)) begin
            cnt_r   <= 8'h00;
            state_r <= S_STROBE;
          end
        end
        S_STROBE: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == strobe_len - 8'h01) begin
            cnt_r   <= 8'h00;
            state_r <= S_HOLD;
            if (kind_r == OP_RD) begin
              rdata_r <= ctrl_r[CTRL_WIDE_BIT] ? dq_sync : {8'h00, dq_sync[7:0]};
            end
          end
        end
        S_HOLD: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(HOLD_CYC - 1)) begin
            cnt_r <= 8'h00;
            if (kind_r == OP_ADDR && byte_idx_r != ADDR_BYTES - 3'h1) begin
              byte_idx_r <= byte_idx_r + 3'h1;
              state_r    <= S_SETUP;
            end else begin
              state_r <= S_END;
            end
          end
        end
        S_END: state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Address byte for the current cycle; bytes past the third and A20 in word mode are zero
  logic [23:0] addr_eff;
  logic [7:0]  addr_byte;
  always_comb begin
    addr_eff = addr_r;
    if (ctrl_r[CTRL_WIDE_BIT]) begin
      addr_eff[A20_BIT] = 1'b0;
    end
    case (byte_idx_r)
      3'h0:    addr_byte = addr_eff[7:0];
      3'h1:    addr_byte = addr_eff[15:8];
      3'h2:    addr_byte = addr_eff[23:16];
      default: addr_byte = 8'h00;
    endcase
  end

  // Pin drive, registered so every pin comes from a flip-flop
  logic active;
  assign active = (state_r == S_SETUP) || (state_r == S_STROBE) || (state_r == S_HOLD);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins <= PINS_IDLE;
    end else begin
      pins.ce_n               <= !active;
      pins.cle                <= active && kind_r == OP_CMD;
      pins.ale                <= active && kind_r == OP_ADDR;
      pins.we_n               <= !(state_r == S_STROBE && kind_r != OP_RD);
      pins.read_strobe_n      <= !(state_r == S_STROBE && kind_r == OP_RD);
      pins.wp_n               <= ctrl_r[CTRL_WPN_BIT];
      pins.hw_store_request_n <= !ctrl_r[CTRL_HSR_BIT];
    end
  end

  // Commands and addresses ride the low lane only; upper lane for word data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_o  <= 16'h0000;
      dq_oe <= 2'h0;
    end else begin
      dq_oe <= 2'h0;
      dq_o  <= 16'h0000;
      if (active && kind_r != OP_RD) begin
        dq_oe[0] <= 1'b1;
        case (kind_r)
          OP_CMD:  dq_o[7:0] <= wdata_r[7:0];
          OP_ADDR: dq_o[7:0] <= addr_byte;
          default: begin
            dq_o     <= ctrl_r[CTRL_WIDE_BIT] ? wdata_r : {8'h00, wdata_r[7:0]};
            dq_oe[1] <= ctrl_r[CTRL_WIDE_BIT];
          end
        endcase
      end
    end
  end

  // Checks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_edges_r <= 3'h0;
    end else if (pins.ce_n) begin
      addr_edges_r <= 3'h0;
    end else if (pins.ale && !pins.we_n && dq_oe[0] && $past(pins.we_n)) begin
      addr_edges_r <= addr_edges_r + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_addr_five_bytes: assert property (
    (state_r == S_END && kind_r == OP_ADDR) |-> addr_edges_r == ADDR_BYTES)
    else $error("address phase did not send five bytes");
  chk_addr_high_zero: assert property (
    (pins.ale && !pins.we_n && addr_edges_r > ADDR_USED) |-> dq_o[7:0] == 8'h00)
    else $error("unused address byte not zero");
  chk_upper_lane_quiet: assert property (
    (pins.cle || pins.ale) |-> !dq_oe[1])
    else $error("upper lane driven during command or address");
  chk_wait_power_ready: assert property (
    !powered_r |-> ##1 pins.ce_n)
    else $error("bus cycle before device ready");
  chk_cycle_kind_stable: assert property (
    (!pins.ce_n && $past(!pins.ce_n)) |-> ($stable(pins.cle) && $stable(pins.ale)))
    else $error("cycle kind changed inside transaction");
  chk_strobe_width: assert property (
    $fell(pins.we_n) |-> !pins.we_n [*3] ##1 pins.we_n)
    else $error("write strobe width wrong");

  cov_addr_phase: cover property (state_r == S_END && kind_r == OP_ADDR);
  cov_read_word: cover property (state_r == S_END && kind_r == OP_RD && ctrl_r[CTRL_WIDE_BIT]);
  cov_refused: cover property ($rose(refused_r));
endmodule
`default_nettype wire

//--- test/anbp_dev_model.sv
// Behavioural model of the nonvolatile SRAM behind the host port
`timescale 1ns/1ps
`default_nettype none
module anbp_dev_model
  import anbp_pkg::*;
#(
  parameter int RECALL_CYC = 60,
  parameter int STORE_CYC  = 40
) (
  input  wire logic                    clk,
  input  wire anbp_pkg::anbp_pins_type pins,
  input  wire logic [15:0]             dq,
  input  wire logic                    wide,
  output logic [15:0]                  dev_dq,
  output logic [1:0]                   dev_oe,
  output logic                         rb_low
);
  import anbp_pkg::*;
  int          busy_cnt = RECALL_CYC;
  logic [7:0]  last_cmd = 8'h00;
  logic [7:0]  abyte [5];
  int          acnt = 0;
  logic [15:0] mem [int];
  logic        busy;

  assign busy   = busy_cnt > 0;
  // Open drain on the real part; the bench inverts rb_low to make the high level
  assign rb_low = busy;

  // Counted on clk only for convenience; the real part has no clock
  always @(posedge clk) begin
    if (!pins.hw_store_request_n) begin
      busy_cnt <= STORE_CYC;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
    end
  end

  function automatic int loc();
    return {11'h000, abyte[2][4:0], abyte[1], abyte[0]};
  endfunction

  // All pins are taken at the write-strobe rise
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.read_strobe_n) begin
      if (pins.cle && !pins.ale) begin
        if (!busy || dq[7:0] == CMD_STATUS || dq[7:0] == CMD_RESET) begin
          last_cmd = dq[7:0];
          acnt = 0;
        end
      end else if (pins.ale && !pins.cle && !busy) begin
        abyte[acnt % 5] = dq[7:0];
        acnt++;
      end else if (!pins.ale && !pins.cle && !busy && pins.wp_n) begin
        mem[loc()] = wide ? dq : {8'h00, dq[7:0]};
      end
    end
  end

  always @(negedge pins.read_strobe_n) begin
    if (!pins.ce_n && !pins.ale && !pins.cle && pins.we_n && !busy) begin
      dev_dq = mem.exists(loc()) ? mem[loc()] : 16'h0000;
      dev_oe = wide ? 2'h3 : 2'h1;
    end
  end

  // Released lines go to the bench pattern, never the stale value
  always @(posedge pins.read_strobe_n or posedge pins.ce_n) begin
    dev_oe = 2'h0;
  end

  initial begin
    dev_oe = 2'h0;
    dev_dq = 16'h0000;
  end
endmodule
`default_nettype wire

//--- test/anbp_host_tb.sv
// Self-checking bench for the NAND-style bus host port
`timescale 1ns/1ps
`default_nettype none
module anbp_host_tb;
  import anbp_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wide = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, dq_oe, dev_oe;
  logic [15:0] dq_o, dq_i, dev_dq;
  logic        rb_low;
  anbp_pins_type pins;
  int          cyc = 0, miscompares = 0, tests_run = 0;

  always #5 clk = ~clk;
  // Undriven lines show a changing pattern
  assign dq_i[7:0]  = dq_oe[0] ? dq_o[7:0] : (dev_oe[0] ? dev_dq[7:0] : cyc[7:0]);
  assign dq_i[15:8] = dq_oe[1] ? dq_o[15:8] : (dev_oe[1] ? dev_dq[15:8] : cyc[15:8]);

  anbp_host u_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pins(pins), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
    .ready_busy_i(~rb_low));
  anbp_dev_model u_dev (.clk(clk), .pins(pins), .dq(dq_i), .wide(wide), .dev_dq(dev_dq),
    .dev_oe(dev_oe), .rb_low(rb_low));

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_rd(a, d, r);
  endtask
  task automatic set_ctrl(input logic [2:0] v);
    wr(REG_CTRL, {29'h0, v});
    wide = v[1];
  endtask
  // Bounded wait on one status bit
  task automatic poll(input int bitn, input logic lvl);
    logic [31:0] d;
    int          n;
    n = 0;
    do begin
      rd(REG_STATUS, d);
      n++;
    end while (d[bitn] !== lvl && n < 200);
    cmp({31'h0, d[bitn]}, {31'h0, lvl}, "status poll");
  endtask
  task automatic op(input logic [1:0] k, input logic [15:0] v);
    wr(REG_OP, {14'h0000, k, v});
    poll(ST_BUSY_BIT, 1'b0);
  endtask

  task automatic t_powerup();
    logic [31:0] d;
    logic [1:0]  r;
    rd(REG_CTRL, d);
    cmp(d, {29'h0, CTRL_RESET}, "ctrl reset");
    axi_wr(REG_OP, 32'h0000_0080, r);
    cmp({30'h0, r}, {30'h0, RESP_OKAY}, "early op resp");
    rd(REG_STATUS, d);
    cmp({31'h0, d[ST_REFUSED_BIT]}, 32'h1, "early op refused");
    poll(ST_POWERED_BIT, 1'b1);
    wr(REG_STATUS, 32'h4);
    rd(REG_STATUS, d);
    cmp(d, 32'hA, "status ready");
    axi_rd(8'h20, d, r);
    cmp({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    axi_wr(8'h24, 32'h0, r);
    cmp({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    $display("t_powerup done");
  endtask

  task automatic t_cmd_addr();
    set_ctrl(3'h1);
    wr(REG_ADDR, 32'h001F5AC3);
    op(2'h0, 16'h0080);
    cmp({24'h0, u_dev.last_cmd}, 32'h80, "command byte");
    op(2'h1, 16'h0000);
    cmp({8'h0, u_dev.abyte[2], u_dev.abyte[1], u_dev.abyte[0]}, 32'h1F5AC3, "addr low");
    cmp({16'h0, u_dev.abyte[4], u_dev.abyte[3]}, 32'h0, "addr spare");
    set_ctrl(3'h3);
    op(2'h1, 16'h0000);
    cmp({24'h0, u_dev.abyte[2]}, 32'h0F, "a20 cleared");
    $display("t_cmd_addr done");
  endtask

  task automatic t_data();
    logic [31:0] d;
    set_ctrl(3'h3);
    wr(REG_ADDR, 32'h00012345);
    op(2'h0, 16'h0080);
    op(2'h1, 16'h0000);
    op(2'h2, 16'hBEEF);
    cmp({16'h0, u_dev.mem[32'h12345]}, 32'hBEEF, "word write");
    set_ctrl(3'h2);
    op(2'h2, 16'h1111);
    cmp({16'h0, u_dev.mem[32'h12345]}, 32'hBEEF, "protected write");
    set_ctrl(3'h3);
    op(2'h0, 16'h0000);
    op(2'h1, 16'h0000);
    op(2'h3, 16'h0000);
    rd(REG_RDATA, d);
    cmp(d, 32'hBEEF, "word read");
    set_ctrl(3'h1);
    op(2'h3, 16'h0000);
    rd(REG_RDATA, d);
    cmp(d, 32'h00EF, "byte read");
    $display("t_data done");
  endtask

  task automatic t_store();
    logic [31:0] d;
    set_ctrl(3'h5);
    poll(ST_RDY_BIT, 1'b0);
    wr(REG_OP, 32'h0000_0080);
    rd(REG_STATUS, d);
    cmp({31'h0, d[ST_REFUSED_BIT]}, 32'h1, "busy cmd refused");
    wr(REG_STATUS, 32'h4);
    op(2'h0, 16'h0070);
    cmp({24'h0, u_dev.last_cmd}, 32'h70, "status cmd taken");
    rd(REG_STATUS, d);
    cmp({31'h0, d[ST_REFUSED_BIT]}, 32'h0, "status cmd allowed");
    wr(REG_OP, 32'h0001_0000);
    rd(REG_STATUS, d);
    cmp({31'h0, d[ST_REFUSED_BIT]}, 32'h1, "busy addr refused");
    wr(REG_STATUS, 32'h4);
    set_ctrl(3'h1);
    poll(ST_RDY_BIT, 1'b1);
    $display("t_store done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_powerup();
    t_cmd_addr();
    t_data();
    t_store();
    tally_and_finish();
  end
endmodule
`default_nettype wire
